// ### logic/rsic_defs.vh
// Function
// R1: reset on power-on, low reset pin, or enabled watchdog timeout.
// R2: hold reset for one start-up timer period, about 18 ms.
// R3: every reset loads the program counter with all ones.
// R4: power-on reset alone clears status bits 5,6 and bank select bits 7,6.
// R5: every reset sets all port pins to input, drivers high impedance.
// R6: reset clears watchdog and prescaler; watchdog enabled when code option is one.
// R7: reset sets option control register to ones except bit 6.
// R8: reset sets port 6 wake mask to all ones.
// R9: reset clears watchdog control bits 3,6 and sets bits 0,4,5.
// R10: reset clears bits 0,3 of interrupt flag and mask registers.
// R11: sleep instruction enters halt sleep and clears watchdog; watchdog keeps counting.
// R12: halt sleep wakes only on watchdog timeout or reset pin, via full reset.
// R13: status timeout and power-down flags record the reset or wake cause.
// R14: clearing oscillator run bit stops oscillator; enabled pin wake resumes without reset.
// R15: after a pin wake, watchdog enabled when code option is one.
// R16: in oscillator-stop sleep, watchdog timeout or reset pin performs full reset.
// R17: timer overflow and external interrupts vector to address 001H.
// R18: enable instruction sets, disable instruction clears global interrupt enable.
// R19: interrupt events set flags regardless of mask or global enable.
// R20: reading interrupt flag register returns flags AND mask.
// R21: return-from-interrupt pops return address and sets global enable.
// R22: software trap pushes return address and vectors to 002H.
// R23: run bit set at wake falling edge; its edges stop and restart oscillator.
// R24: port 6 wake mask bit 0 enables, 1 disables its pin wake.
// R25: taking a hardware interrupt clears global enable.
// R26: interrupt taken only when flag, mask and global enable set, at instruction boundary.
`ifndef RSIC_DEFS_VH
`define RSIC_DEFS_VH
`define RSIC_A_STATUS 32'h0000_0000
`define RSIC_A_BANK 32'h0000_0004
`define RSIC_A_OPTION 32'h0000_0008
`define RSIC_A_WAKEMASK 32'h0000_000C
`define RSIC_A_WDTCTL 32'h0000_0010
`define RSIC_A_IRQFLAG 32'h0000_0014
`define RSIC_A_IRQMASK 32'h0000_0018
`define RSIC_A_PCTRL 32'h0000_001C
`define RSIC_A_PCVAL 32'h0000_0020
`define RSIC_A_DIR 32'h0000_0024
`define RSIC_A_STATE 32'h0000_0028
`define RSIC_A_WDTCNT 32'h0000_002C
`define RSIC_OPT_RST 8'hBF
`define RSIC_WAKE_RST 8'hFF
`define RSIC_WDC_RST 8'h31
`define RSIC_WDC_KEEP 8'h86
`define RSIC_IRQ_KEEP 8'hF6
`define RSIC_ST_TO 4
`define RSIC_ST_PD 3
`define RSIC_WDC_WTE 5
`define RSIC_WDC_RUN 4
`define RSIC_WDC_PWN 0
`define RSIC_IRQ_TC 0
`define RSIC_IRQ_EX 3
`define RSIC_OPT_GIE 6
`define RSIC_OST_MS 18
`define RSIC_CLK_KHZ 100000
`define RSIC_OST_CYC (`RSIC_OST_MS * `RSIC_CLK_KHZ)
`define RSIC_VEC_IRQ 12'h001
`define RSIC_VEC_TRAP 12'h002
`define RSIC_PC_ONES 12'hFFF
`endif

// ### logic/rsic_ctrl.v
// Chosen here: the AHB-Lite register port and the address map.
`include "rsic_defs.vh"
`default_nettype none
module rsic_ctrl #(
  parameter integer OST_CYCLES = `RSIC_OST_CYC,
  parameter integer WDT_CYCLES = `RSIC_OST_CYC
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire por_in,
  input wire ext_reset_n_in,
  input wire wdt_code_option_in,
  input wire [7:0] port6_pins_in,
  input wire [1:0] port7_wake_pins_in,
  input wire timer_clock_counter_ovf_in,
  input wire ext_irq_n_in,
  input wire instr_boundary_in,
  input wire sleep_instr_in,
  input wire wdt_clear_instr_in,
  input wire irq_global_on_instr_in,
  input wire irq_global_off_instr_in,
  input wire irq_return_instr_in,
  input wire trap_instr_in,
  input wire [11:0] return_addr_in,
  input wire [11:0] stack_top_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hsel_in,
  input wire hready_in,
  output wire [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  output wire core_reset_out,
  output wire osc_run_out,
  output reg pc_load_out,
  output reg [11:0] pc_value_out,
  output reg stack_push_out,
  output reg [11:0] stack_push_data_out,
  output reg [7:0] port_dir_out
);

  // ************************************************
  // state and inputs
  // ************************************************
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_HALT = 2'd1;
  localparam [1:0] ST_OSTOP = 2'd2;
  localparam [1:0] ST_RESET = 2'd3;

  reg [1:0] state_q;
  reg [31:0] ost_q;
  reg [31:0] wdt_q;
  reg [7:0] status_q;
  reg [7:0] bank_q;
  reg [7:0] option_q;
  reg [7:0] wakemask_q;
  reg [7:0] wdtctl_q;
  reg [7:0] irqflag_q;
  reg [7:0] irqmask_q;
  reg por_s1_q;
  reg por_s2_q;
  reg [10:0] pin_s1_q;
  reg [10:0] pin_s2_q;
  reg [10:0] pin_s3_q;
  reg run_d1_q;
  reg [31:0] hrdata_q;
  reg [31:0] addr_q;
  reg wr_q;
  wire por_s = por_s2_q;
  wire rstpin_low = ~pin_s2_q[8];
  wire [7:0] p6 = pin_s2_q[7:0];
  wire [1:0] p7 = pin_s2_q[10:9];
  reg ext_s1_q, ext_s2_q, ext_s3_q;
  wire ext_fall = ext_s3_q & ~ext_s2_q;
  wire wdt_en = wdt_code_option_in & wdtctl_q[`RSIC_WDC_WTE];
  wire wdt_to = wdt_en && (wdt_q >= WDT_CYCLES - 1);
  wire [7:0] p6_fall = pin_s3_q[7:0] & ~p6;
  wire [1:0] p7_fall = pin_s3_q[10:9] & ~p7;
  // R24 mask bit low enables the pin
  wire pin_wake = (|(p6_fall & ~wakemask_q)) |
                  ((|p7_fall) & ~wdtctl_q[`RSIC_WDC_PWN]);
  wire reset_ev = por_s | rstpin_low | wdt_to; // R1 R12 R16
  wire [7:0] pend = irqflag_q & irqmask_q & 8'h09;
  wire irq_take = (state_q == ST_RUN) && instr_boundary_in && (|pend) &&
                  option_q[`RSIC_OPT_GIE]; // R26

  assign core_reset_out = (state_q == ST_RESET);
  // R23 oscillator follows the run bit; halt sleep also stops it
  assign osc_run_out = wdtctl_q[`RSIC_WDC_RUN] & (state_q != ST_HALT);
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;

  // ************************************************
  // synchronisers
  // ************************************************
  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      por_s1_q <= 1'b0;
      por_s2_q <= 1'b0;
      pin_s1_q <= 11'h7FF;
      pin_s2_q <= 11'h7FF;
      pin_s3_q <= 11'h7FF;
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_s3_q <= 1'b1;
    end
    else
    begin
      por_s1_q <= por_in;
      por_s2_q <= por_s1_q;
      pin_s1_q <= {port7_wake_pins_in, ext_reset_n_in, port6_pins_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      ext_s1_q <= ext_irq_n_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // ************************************************
  // sequencer and registers
  // ************************************************
  wire bus_ok = hsel_in & hready_in & htrans_in[1];
  wire do_wr = wr_q;
  wire rd_req = bus_ok & ~hwrite_in;

  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q <= ST_RESET;
      ost_q <= 32'h0000_0000;
      wdt_q <= 32'h0000_0000;
      status_q <= 8'h18;
      bank_q <= 8'h00;
      option_q <= `RSIC_OPT_RST;
      wakemask_q <= `RSIC_WAKE_RST;
      wdtctl_q <= `RSIC_WDC_RST;
      irqflag_q <= 8'h00;
      irqmask_q <= 8'h00;
      run_d1_q <= 1'b1;
      pc_load_out <= 1'b0;
      pc_value_out <= `RSIC_PC_ONES;
      stack_push_out <= 1'b0;
      stack_push_data_out <= 12'h000;
      port_dir_out <= 8'hFF;
      addr_q <= 32'h0000_0000;
      wr_q <= 1'b0;
    end
    else
    begin
      pc_load_out <= 1'b0;
      stack_push_out <= 1'b0;
      run_d1_q <= wdtctl_q[`RSIC_WDC_RUN];
      wr_q <= bus_ok & hwrite_in;
      if (bus_ok)
        addr_q <= haddr_in;
      // watchdog counts in every state except reset, also during sleep
      if (wdt_en && state_q != ST_RESET)
        wdt_q <= wdt_to ? 32'h0000_0000 : wdt_q + 32'h0000_0001;
      else
        wdt_q <= 32'h0000_0000;
      // R19 flags set regardless of mask and enable; set beats clear
      if (do_wr && addr_q == `RSIC_A_IRQFLAG)
        irqflag_q <= hwdata_in[7:0] & 8'h09;
      if (timer_clock_counter_ovf_in)
        irqflag_q[`RSIC_IRQ_TC] <= 1'b1; // R19
      if (ext_fall)
        irqflag_q[`RSIC_IRQ_EX] <= 1'b1; // R19
      if (do_wr)
      begin
        case (addr_q)
          `RSIC_A_STATUS: status_q <= (hwdata_in[7:0] & 8'hE7) | (status_q & 8'h18);
          `RSIC_A_BANK: bank_q <= hwdata_in[7:0];
          `RSIC_A_OPTION: option_q <= (hwdata_in[7:0] & 8'hBF) | (option_q & 8'h40);
          `RSIC_A_WAKEMASK: wakemask_q <= hwdata_in[7:0];
          `RSIC_A_WDTCTL: wdtctl_q <= hwdata_in[7:0] & 8'h79;
          `RSIC_A_IRQMASK: irqmask_q <= hwdata_in[7:0] & 8'h09;
          `RSIC_A_DIR: port_dir_out <= hwdata_in[7:0];
          default: ;
        endcase
      end
      if (irq_global_on_instr_in)
        option_q[`RSIC_OPT_GIE] <= 1'b1; // R18
      if (irq_global_off_instr_in)
        option_q[`RSIC_OPT_GIE] <= 1'b0; // R18
      if (wdt_clear_instr_in)
      begin
        wdt_q <= 32'h0000_0000;
        status_q[`RSIC_ST_TO] <= 1'b1;
        status_q[`RSIC_ST_PD] <= 1'b1;
      end
      case (state_q)
        ST_RUN:
        begin
          if (irq_return_instr_in)
          begin
            pc_load_out <= 1'b1; // R21
            pc_value_out <= stack_top_in; // R21
            option_q[`RSIC_OPT_GIE] <= 1'b1; // R21
          end
          else if (trap_instr_in)
          begin
            stack_push_out <= 1'b1; // R22
            stack_push_data_out <= return_addr_in;
            pc_load_out <= 1'b1;
            pc_value_out <= `RSIC_VEC_TRAP; // R22
          end
          else if (irq_take)
          begin
            stack_push_out <= 1'b1;
            stack_push_data_out <= return_addr_in;
            pc_load_out <= 1'b1;
            pc_value_out <= `RSIC_VEC_IRQ; // R17
            option_q[`RSIC_OPT_GIE] <= 1'b0; // R25
          end
          if (sleep_instr_in)
          begin
            state_q <= ST_HALT; // R11
            wdt_q <= 32'h0000_0000; // R11
            status_q[`RSIC_ST_TO] <= 1'b1; // R13
            status_q[`RSIC_ST_PD] <= 1'b0; // R13
          end
          else if (run_d1_q && !wdtctl_q[`RSIC_WDC_RUN])
            state_q <= ST_OSTOP; // R14 R23
        end
        ST_HALT: ;
        ST_OSTOP:
        begin
          if (pin_wake)
          begin
            wdtctl_q[`RSIC_WDC_RUN] <= 1'b1; // R23
            wdtctl_q[`RSIC_WDC_WTE] <= wdt_code_option_in; // R15
            state_q <= ST_RESET; // R2 start-up wait, no reset effects
            ost_q <= 32'h0000_0001;
          end
        end
        default:
        begin
          if (ost_q != 32'h0000_0000)
          begin
            // pin wake: only the start-up wait, then resume in line
            if (ost_q >= OST_CYCLES)
            begin
              ost_q <= 32'h0000_0000;
              state_q <= ST_RUN; // R14
            end
            else
              ost_q <= ost_q + 32'h0000_0001;
          end
        end
      endcase
      // full reset sequence overrides everything else
      if (reset_ev || (state_q == ST_RESET && ost_q == 32'h0000_0000))
      begin
        if (reset_ev)
        begin
          state_q <= ST_RESET; // R1
          wdt_q <= 32'h0000_0000; // R6
          option_q <= `RSIC_OPT_RST | (option_q & 8'h40); // R7
          wakemask_q <= `RSIC_WAKE_RST; // R8
          wdtctl_q <= (wdtctl_q & `RSIC_WDC_KEEP) | `RSIC_WDC_RST; // R9 R6
          irqflag_q <= irqflag_q & `RSIC_IRQ_KEEP; // R10
          irqmask_q <= irqmask_q & `RSIC_IRQ_KEEP; // R10
          port_dir_out <= 8'hFF; // R5
          pc_value_out <= `RSIC_PC_ONES; // R3
          ost_q <= 32'h0000_0000;
          wdtctl_q[`RSIC_WDC_WTE] <= 1'b1;
          if (por_s)
          begin
            status_q <= (status_q & 8'h9F) | 8'h18; // R4 R13
            bank_q <= bank_q & 8'h3F; // R4
          end
          else if (wdt_to)
          begin
            status_q[`RSIC_ST_TO] <= 1'b0; // R13
            status_q[`RSIC_ST_PD] <= (state_q == ST_RUN); // R13
          end
          else if (state_q == ST_HALT || state_q == ST_OSTOP)
          begin
            status_q[`RSIC_ST_TO] <= 1'b1; // R13
            status_q[`RSIC_ST_PD] <= 1'b0;
          end
        end
        else
        begin
          // R2 hold reset for one start-up period after the cause is gone
          if (wdt_q >= OST_CYCLES - 1)
          begin
            state_q <= ST_RUN;
            pc_load_out <= 1'b1; // R3
            pc_value_out <= `RSIC_PC_ONES;
            wdt_q <= 32'h0000_0000;
          end
          else
            wdt_q <= wdt_q + 32'h0000_0001; // R2
        end
      end
    end
  end

  // ************************************************
  // register read port
  // ************************************************
  // read data is taken with the address phase so that it already stands
  // through the zero-wait data phase; limitation: a read issued directly
  // behind a write to the same register returns the value before that write
  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      hrdata_q <= 32'h0000_0000;
    else if (rd_req)
    begin
      // flag read is masked by the enables
      case (haddr_in)
        `RSIC_A_STATUS: hrdata_q <= {24'h000000, status_q};
        `RSIC_A_BANK: hrdata_q <= {24'h000000, bank_q};
        `RSIC_A_OPTION: hrdata_q <= {24'h000000, option_q};
        `RSIC_A_WAKEMASK: hrdata_q <= {24'h000000, wakemask_q};
        `RSIC_A_WDTCTL: hrdata_q <= {24'h000000, wdtctl_q};
        `RSIC_A_IRQFLAG: hrdata_q <= {24'h000000, irqflag_q & irqmask_q}; // R20
        `RSIC_A_IRQMASK: hrdata_q <= {24'h000000, irqmask_q};
        `RSIC_A_PCVAL: hrdata_q <= {20'h00000, pc_value_out};
        `RSIC_A_DIR: hrdata_q <= {24'h000000, port_dir_out};
        `RSIC_A_STATE: hrdata_q <= {30'h0000_0000, state_q};
        `RSIC_A_WDTCNT: hrdata_q <= wdt_q;
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end
endmodule // rsic_ctrl
`default_nettype wire

// ### testbench/rsic_ctrl_assertions.sv
`default_nettype none
module rsic_ctrl_assertions #(
  parameter integer OST_CYCLES = 20
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ext_reset_n_in,
  input wire logic trap_instr_in,
  input wire logic irq_return_instr_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic core_reset_out,
  input wire logic osc_run_out,
  input wire logic pc_load_out,
  input wire logic [11:0] pc_value_out,
  input wire logic stack_push_out,
  input wire logic [7:0] port_dir_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  // ****************************************
  // reset hold counter
  // ****************************************
  logic [31:0] hold_q;
  logic [31:0] hold_d;
  assign hold_d = core_reset_out ? hold_q + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      hold_q <= 32'h0000_0000;
    else
      hold_q <= hold_d;
  end
  chk_bus_okay: assert property (hreadyout_out && !hresp_out) else $error("bus not okay");
  chk_ost_hold: assert property ($fell(core_reset_out) |-> hold_q >= OST_CYCLES - 1)
    else $error("reset released early");
  // a pin wake also holds the core for the start-up wait but loads no pc,
  // so only a release that loads the pc is a full reset
  chk_pc_ones: assert property ($fell(core_reset_out) && pc_load_out |-> pc_value_out == 12'hFFF)
    else $error("reset pc not all ones");
  chk_dir_input: assert property ($fell(core_reset_out) && pc_load_out |-> port_dir_out == 8'hFF)
    else $error("port not input after reset");
  chk_pin_reset: assert property (!ext_reset_n_in [*4] |-> ##[0:3] core_reset_out)
    else $error("pin reset missed");
  chk_trap_vec: assert property (trap_instr_in && !core_reset_out |->
    ##[1:3] (stack_push_out && pc_value_out == 12'h002))
    else $error("trap vector wrong");
  chk_irq_return_instr_load: assert property (irq_return_instr_in && !core_reset_out |-> ##[1:3] pc_load_out)
    else $error("return did not load pc");
  chk_stop_quiet: assert property ($fell(osc_run_out) |-> !pc_load_out [*3])
    else $error("pc loaded while stopped");
  cov_trap: cover property (stack_push_out);
  cov_release: cover property ($fell(core_reset_out));
  cov_stop: cover property ($fell(osc_run_out));
endmodule // rsic_ctrl_assertions
`default_nettype wire

// ### testbench/rsic_core_model.sv
`default_nettype none
module rsic_core_model (
  input wire logic clk_in,
  output logic ext_reset_n_out,
  output logic [7:0] port6_out,
  output logic [6:0] instr_out,
  output logic [11:0] return_addr_out,
  output logic [11:0] stack_top_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // core side pins and instruction pulses
  // ****************************************
  // pins sit high on their pull-ups when nobody pulls them down
  initial
  begin
    ext_reset_n_out = 1'b1;
    port6_out = 8'hFF;
    instr_out = 7'h00;
    return_addr_out = 12'h1C7;
    stack_top_out = 12'h3A5;
  end
  // bit k: boundary, sleep, wdt clear, irq on, irq off, irq return, trap
  task automatic pulse(input int k);
    @(posedge clk_in);
    instr_out <= 7'h01 << k;
    @(posedge clk_in);
    instr_out <= 7'h00;
  endtask
  task automatic pin_reset();
    @(posedge clk_in);
    ext_reset_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    ext_reset_n_out <= 1'b1;
  endtask
  task automatic wake_pin();
    @(posedge clk_in);
    port6_out <= 8'hFE;
    repeat (6) @(posedge clk_in);
    port6_out <= 8'hFF;
  endtask
endmodule // rsic_core_model
`default_nettype wire

// ### testbench/reset_sleep_interrupt_ctrl_tb_top.sv
`include "rsic_defs.vh"
`default_nettype none
module reset_sleep_interrupt_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer OST = 20;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, por = 1'b0, ovf = 1'b0, ext_irq_n = 1'b1;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, v, s_pin, s_wdt;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic wdt_opt = 1'b1;
  logic hsel = 1'b0;
  logic [1:0] p7 = 2'b11;
  logic [2:0] hsize = 3'b010;
  wire hready, hresp, ext_rst_n, core_reset_out, osc_run_out, pc_load_out, stack_push_out;
  wire [7:0] p6, pdir;
  wire [6:0] ins;
  wire [11:0] ret_a, top_a, pc_value_out, push_d;
  int n_mismatch = 0, n_checks = 0, n_load = 0;
  logic [11:0] last_pc = 12'h000, last_push = 12'h000;
  always #5 ref_clk_in = ~ref_clk_in;
  rsic_core_model core_u (.clk_in(ref_clk_in), .ext_reset_n_out(ext_rst_n), .port6_out(p6),
    .instr_out(ins), .return_addr_out(ret_a), .stack_top_out(top_a));
  rsic_ctrl #(.OST_CYCLES(OST), .WDT_CYCLES(2000)) dut_u (.ref_clk_in, .reset_in,
    .por_in(por), .ext_reset_n_in(ext_rst_n), .wdt_code_option_in(wdt_opt), .port6_pins_in(p6),
    .port7_wake_pins_in(p7), .timer_clock_counter_ovf_in(ovf), .ext_irq_n_in(ext_irq_n),
    .instr_boundary_in(ins[0]), .sleep_instr_in(ins[1]), .wdt_clear_instr_in(ins[2]),
    .irq_global_on_instr_in(ins[3]), .irq_global_off_instr_in(ins[4]),
    .irq_return_instr_in(ins[5]), .trap_instr_in(ins[6]), .return_addr_in(ret_a),
    .stack_top_in(top_a), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hsel_in(hsel), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .core_reset_out,
    .osc_run_out, .pc_load_out, .pc_value_out, .stack_push_out,
    .stack_push_data_out(push_d), .port_dir_out(pdir));
  always @(posedge ref_clk_in)
  begin
    if (pc_load_out === 1'b1)
    begin
      n_load <= n_load + 1;
      last_pc <= pc_value_out;
    end
    if (stack_push_out === 1'b1)
      last_push <= push_d;
  end
  // ****************************************
  // bus, compare and closing tasks
  // ****************************************
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk_in);
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    @(posedge ref_clk_in);
    while (hready !== 1'b1) @(posedge ref_clk_in);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge ref_clk_in);
    while (hready !== 1'b1) @(posedge ref_clk_in);
    // read data and response stand in the data phase and are taken at its closing edge
    q = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic boot(input bit wd_off);
    int i;
    i = 0;
    repeat (6) @(posedge ref_clk_in);
    while (core_reset_out !== 1'b0 && i < 500)
    begin
      @(posedge ref_clk_in);
      i++;
    end
    chk(core_reset_out, 0);
    // watchdog is on after reset; stop it so it cannot cut a scenario short
    if (wd_off) wr(`RSIC_A_WDTCTL, 32'h0000_0011);
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fire_ovf();
    @(posedge ref_clk_in);
    ovf <= 1'b1;
    @(posedge ref_clk_in);
    ovf <= 1'b0;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    stop_test();
  end
  // ****************************************
  // scenarios
  // ****************************************
  logic [31:0] ra [5] = '{`RSIC_A_OPTION, `RSIC_A_WAKEMASK, `RSIC_A_WDTCTL,
                          `RSIC_A_IRQFLAG, `RSIC_A_IRQMASK};
  logic [31:0] rm [5] = '{32'hFF, 32'hFF, 32'h79, 32'h09, 32'h09};
  logic [31:0] re [5] = '{32'hBF, 32'hFF, 32'h31, 32'h00, 32'h00};
  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    boot(1'b0);
    foreach (ra[i])
    begin
      bus(ra[i], 1'b0, 32'h0, v);
      chk(v & rm[i], re[i]);
    end
    wr(`RSIC_A_WDTCTL, 32'h0000_0011);
    wr(`RSIC_A_BANK, 32'h0000_00FF);
    wr(`RSIC_A_STATUS, 32'h0000_0060);
    core_u.pin_reset();
    boot(1'b1);
    bus(`RSIC_A_BANK, 1'b0, 32'h0, v);
    chk(v & 32'hC0, 32'hC0);
    bus(`RSIC_A_STATUS, 1'b0, 32'h0, s_pin);
    wr(`RSIC_A_DIR, 32'h5A);
    bus(`RSIC_A_DIR, 1'b0, 32'h0, v);
    chk({v[7:0], pdir}, 16'h5A5A);
    por <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    por <= 1'b0;
    boot(1'b1);
    bus(`RSIC_A_BANK, 1'b0, 32'h0, v);
    chk(v & 32'hC0, 32'h0);
    bus(`RSIC_A_STATUS, 1'b0, 32'h0, v);
    chk(v & 32'h60, 32'h0);
    chk(pdir, 8'hFF);
    wr(`RSIC_A_IRQMASK, 32'h0);
    core_u.pulse(3);
    fire_ovf();
    core_u.pulse(0);
    repeat (3) @(posedge ref_clk_in);
    chk(n_load, 1 + 1 + 1);
    bus(`RSIC_A_IRQFLAG, 1'b0, 32'h0, v);
    chk(v & 32'h09, 32'h0);
    wr(`RSIC_A_IRQMASK, 32'h1);
    bus(`RSIC_A_IRQFLAG, 1'b0, 32'h0, v);
    chk(v & 32'h09, 32'h1);
    core_u.pulse(0);
    repeat (3) @(posedge ref_clk_in);
    chk({20'h0, last_pc}, 32'h001);
    core_u.pulse(0);
    repeat (3) @(posedge ref_clk_in);
    chk(n_load, 4);
    core_u.pulse(5);
    repeat (3) @(posedge ref_clk_in);
    chk({20'h0, last_pc}, 32'h3A5);
    wr(`RSIC_A_IRQFLAG, 32'h0);
    ext_irq_n <= 1'b0;
    wr(`RSIC_A_IRQMASK, 32'h9);
    bus(`RSIC_A_IRQFLAG, 1'b0, 32'h0, v);
    chk(v & 32'h09, 32'h8);
    ext_irq_n <= 1'b1;
    wr(`RSIC_A_IRQFLAG, 32'h0);
    core_u.pulse(6);
    repeat (3) @(posedge ref_clk_in);
    chk({last_pc, last_push}, {12'h002, 12'h1C7});
    wr(`RSIC_A_WAKEMASK, 32'hFE);
    wr(`RSIC_A_WDTCTL, 32'h01);
    repeat (3) @(posedge ref_clk_in);
    chk(osc_run_out, 0);
    core_u.wake_pin();
    repeat (OST + 20) @(posedge ref_clk_in);
    chk({osc_run_out, core_reset_out, n_load[7:0]}, {2'b10, 8'd6});
    // second stop, woken this time by a port 7 pin enabled in the control register
    wr(`RSIC_A_WDTCTL, 32'h00);
    repeat (3) @(posedge ref_clk_in);
    chk(osc_run_out, 0);
    p7 <= 2'b10;
    repeat (6) @(posedge ref_clk_in);
    p7 <= 2'b11;
    repeat (OST + 20) @(posedge ref_clk_in);
    chk({osc_run_out, core_reset_out, n_load[7:0]}, {2'b10, 8'd6});
    bus(`RSIC_A_WDTCTL, 1'b0, 32'h0, v);
    chk(v & 32'h30, 32'h30);
    core_u.pulse(1);
    core_u.wake_pin();
    repeat (OST + 20) @(posedge ref_clk_in);
    chk(n_load, 6);
    core_u.pin_reset();
    boot(1'b1);
    chk({20'h0, last_pc}, 32'hFFF);
    wr(`RSIC_A_WDTCTL, 32'h31);
    repeat (2100) @(posedge ref_clk_in);
    boot(1'b1);
    bus(`RSIC_A_STATUS, 1'b0, 32'h0, s_wdt);
    chk(n_load, 8);
    chk(s_wdt[4] ^ s_pin[4], 1);
    wr(`RSIC_A_WDTCTL, 32'h31);
    repeat (50) @(posedge ref_clk_in);
    bus(`RSIC_A_WDTCNT, 1'b0, 32'h0, v);
    chk(v > 32'd40, 1);
    wdt_opt <= 1'b0;
    repeat (50) @(posedge ref_clk_in);
    bus(`RSIC_A_WDTCNT, 1'b0, 32'h0, v);
    chk(v, 0);
    stop_test();
  end
endmodule // reset_sleep_interrupt_ctrl_tb_top
bind rsic_ctrl rsic_ctrl_assertions #(.OST_CYCLES(OST_CYCLES)) chk_u (.ref_clk_in, .reset_in,
  .ext_reset_n_in, .trap_instr_in, .irq_return_instr_in, .hreadyout_out, .hresp_out,
  .core_reset_out, .osc_run_out, .pc_load_out, .pc_value_out, .stack_push_out, .port_dir_out);
`default_nettype wire
